// ==== pkg/gppw_consts.svh ====
// Constants of the six-port GPIO block: map, masks, reset values
`ifndef GPPW_CONSTS_SVH
`define GPPW_CONSTS_SVH

`define GPPW_NUM_PORTS 3'h6
`define GPPW_PORT_A 3'h0
`define GPPW_PORT_D 3'h3
`define GPPW_PORT_E 3'h4

// Address fields: [7:5] page, [4:2] port, [1:0] register kind
`define GPPW_PAGE_PORTS 3'h0
`define GPPW_OFS_STRENGTH 8'h18
`define GPPW_OFS_DRIVE0 8'h19
`define GPPW_OFS_DRIVE1 8'h1a
`define GPPW_OFS_DRIVE2 8'h1b

`define GPPW_MASK_FULL 8'hff
`define GPPW_MASK_PORT_D 8'h0f
`define GPPW_MASK_PORT_E 8'h1f
`define GPPW_MASK_DRIVE1 8'h3f
`define GPPW_MASK_STRENGTH 8'h01

`define GPPW_RST_DATA 8'hff
`define GPPW_RST_DIR 8'hff
`define GPPW_RST_ZERO 8'h00

`define GPPW_BIT_STRENGTH 0

`endif

// ==== pkg/gppw_pkg.sv ====
// Types of the six-port GPIO block
package gppw_pkg;
  typedef logic [7:0] gppw_byte_t;
  typedef logic [5:0][7:0] gppw_ports_t;
  typedef enum logic [1:0] {
    GPPW_KIND_DATA = 2'b00,
    GPPW_KIND_DIR = 2'b01,
    GPPW_KIND_PULL = 2'b10,
    GPPW_KIND_WAKE = 2'b11
  } gppw_kind_t;
endpackage

// ==== core/gppw_top.sv ====
// Six-port GPIO block with pull-ups, port A wake-up and drive levels
`include "gppw_consts.svh"

module gppw_top (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Data memory access
  input wire gppw_pkg::gppw_byte_t i_addr,
  input wire logic i_wr,
  input wire gppw_pkg::gppw_byte_t i_wdata,
  input wire logic i_rd,
  output gppw_pkg::gppw_byte_t o_rdata,
  // Pins
  input wire gppw_pkg::gppw_ports_t i_pin,
  output gppw_pkg::gppw_ports_t o_pin_out,
  output gppw_pkg::gppw_ports_t o_pin_oe,
  // Pin-shared function state
  input wire gppw_pkg::gppw_ports_t i_func_logic_in,
  input wire gppw_pkg::gppw_ports_t i_func_nmos_out,
  input wire gppw_pkg::gppw_byte_t i_porta_gpio,
  // Pad control
  output gppw_pkg::gppw_ports_t o_pullup_en,
  output logic o_pullup_strong,
  output gppw_pkg::gppw_byte_t o_drive_sel0,
  output gppw_pkg::gppw_byte_t o_drive_sel1,
  output gppw_pkg::gppw_byte_t o_drive_sel2,
  // Power-down wake
  input wire logic i_power_down,
  output logic o_wake_req
);
  import gppw_pkg::*;

  function automatic gppw_byte_t f_mask(input logic [2:0] port);
    if (port == `GPPW_PORT_D) begin
      f_mask = `GPPW_MASK_PORT_D;
    end else if (port == `GPPW_PORT_E) begin
      f_mask = `GPPW_MASK_PORT_E;
    end else begin
      f_mask = `GPPW_MASK_FULL;
    end
  endfunction

  function automatic logic f_hit(input gppw_byte_t addr, input logic [2:0] port,
                                 input gppw_kind_t kind);
    f_hit = (addr[7:5] == `GPPW_PAGE_PORTS) && (addr[4:2] == port) &&
            (addr[1:0] == kind);
  endfunction

  gppw_ports_t data_q;
  gppw_ports_t data_d;
  gppw_ports_t dir_q;
  gppw_ports_t dir_d;
  gppw_ports_t pull_q;
  gppw_ports_t pull_d;
  gppw_ports_t oe_q;
  gppw_ports_t pullup_en_q;
  gppw_ports_t pullup_en_d;
  gppw_ports_t port_rd_val;
  gppw_byte_t wake_en_q;
  gppw_byte_t wake_en_d;
  gppw_byte_t strength_q;
  gppw_byte_t strength_d;
  gppw_byte_t drive0_q;
  gppw_byte_t drive0_d;
  gppw_byte_t drive1_q;
  gppw_byte_t drive1_d;
  gppw_byte_t drive2_q;
  gppw_byte_t drive2_d;
  gppw_byte_t prev_a_q;
  gppw_byte_t fall_a;
  gppw_byte_t rdata_q;
  gppw_byte_t rdata_d;
  logic wake_q;
  logic wake_d;
  logic port_page;
  logic port_valid;
  logic wr_wake_hit;
  logic wr_strength_hit;
  logic wr_drive0_hit;
  logic wr_drive1_hit;
  logic wr_drive2_hit;
  logic reg_hit;

  genvar p;
  generate
    for (p = 0; p < 6; p++) begin : g_port
      assign data_d[p] = (i_wr && f_hit(i_addr, 3'(p), GPPW_KIND_DATA)) ?
                         (i_wdata & f_mask(3'(p))) : data_q[p];
      assign dir_d[p] = (i_wr && f_hit(i_addr, 3'(p), GPPW_KIND_DIR)) ?
                        (i_wdata & f_mask(3'(p))) : dir_q[p];
      assign pull_d[p] = (i_wr && f_hit(i_addr, 3'(p), GPPW_KIND_PULL)) ?
                         (i_wdata & f_mask(3'(p))) : pull_q[p];
      // Pull-up only for logic input or open drain
      // Never on a CMOS-driven pin; from next values so no lag
      assign pullup_en_d[p] = pull_d[p] &
                              ((dir_d[p] & i_func_logic_in[p]) | i_func_nmos_out[p]) &
                              dir_d[p] | (pull_d[p] & i_func_nmos_out[p] & dir_d[p]);
      // Inputs read live pins; outputs read the latch
      assign port_rd_val[p] = ((dir_q[p] & i_pin[p]) | (~dir_q[p] & data_q[p])) &
                              f_mask(3'(p));

      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          // Pins start as inputs, latches high
          data_q[p] <= `GPPW_RST_DATA & f_mask(3'(p));
          dir_q[p] <= `GPPW_RST_DIR & f_mask(3'(p));
          oe_q[p] <= `GPPW_RST_ZERO;
          pull_q[p] <= `GPPW_RST_ZERO;
          pullup_en_q[p] <= `GPPW_RST_ZERO;
        end else begin
          data_q[p] <= data_d[p];
          dir_q[p] <= dir_d[p];
          oe_q[p] <= ~dir_d[p] & f_mask(3'(p));
          pull_q[p] <= pull_d[p];
          pullup_en_q[p] <= pullup_en_d[p];
        end
      end
    end
  endgenerate

  // Named write decodes, shared with the checks below
  assign wr_wake_hit = i_wr && f_hit(i_addr, `GPPW_PORT_A, GPPW_KIND_WAKE);
  assign wr_strength_hit = i_wr && (i_addr == `GPPW_OFS_STRENGTH);
  assign wr_drive0_hit = i_wr && (i_addr == `GPPW_OFS_DRIVE0);
  assign wr_drive1_hit = i_wr && (i_addr == `GPPW_OFS_DRIVE1);
  assign wr_drive2_hit = i_wr && (i_addr == `GPPW_OFS_DRIVE2);

  // Per-pin wake enables on port A
  assign wake_en_d = wr_wake_hit ? i_wdata : wake_en_q;
  // Single strength bit, upper bits read zero
  assign strength_d = wr_strength_hit ? (i_wdata & `GPPW_MASK_STRENGTH) : strength_q;
  assign drive0_d = wr_drive0_hit ? i_wdata : drive0_q;
  assign drive1_d = wr_drive1_hit ? (i_wdata & `GPPW_MASK_DRIVE1) : drive1_q;
  assign drive2_d = wr_drive2_hit ? i_wdata : drive2_q;

  // Edge from previous sample, once per transition
  assign fall_a = prev_a_q & ~i_pin[`GPPW_PORT_A] & wake_en_q & i_porta_gpio;
  // Wake request on enabled falling edge
  assign wake_d = i_power_down & (|fall_a);

  assign port_page = (i_addr[7:5] == `GPPW_PAGE_PORTS);
  assign port_valid = port_page && (i_addr[4:2] < `GPPW_NUM_PORTS);
  // Strength and drive registers sit in unused port slot 6 of the port page
  assign reg_hit = (i_addr >= `GPPW_OFS_STRENGTH) && (i_addr <= `GPPW_OFS_DRIVE2);

  // Unmapped addresses read zero
  always_comb begin
    rdata_d = `GPPW_RST_ZERO;
    if (i_addr == `GPPW_OFS_STRENGTH) begin
      rdata_d = strength_q;
    end else if (i_addr == `GPPW_OFS_DRIVE0) begin
      rdata_d = drive0_q;
    end else if (i_addr == `GPPW_OFS_DRIVE1) begin
      rdata_d = drive1_q;
    end else if (i_addr == `GPPW_OFS_DRIVE2) begin
      rdata_d = drive2_q;
    end else if (port_valid) begin
      unique case (gppw_kind_t'(i_addr[1:0]))
        GPPW_KIND_DATA: rdata_d = port_rd_val[i_addr[4:2]];
        GPPW_KIND_DIR: rdata_d = dir_q[i_addr[4:2]];
        GPPW_KIND_PULL: rdata_d = pull_q[i_addr[4:2]];
        GPPW_KIND_WAKE: begin
          rdata_d = (i_addr[4:2] == `GPPW_PORT_A) ? wake_en_q : `GPPW_RST_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wake_en_q <= `GPPW_RST_ZERO;
      strength_q <= `GPPW_RST_ZERO;
      drive0_q <= `GPPW_RST_ZERO;
      drive1_q <= `GPPW_RST_ZERO;
      drive2_q <= `GPPW_RST_ZERO;
      prev_a_q <= `GPPW_RST_ZERO;
      rdata_q <= `GPPW_RST_ZERO;
      wake_q <= 1'b0;
    end else begin
      wake_en_q <= wake_en_d;
      strength_q <= strength_d;
      drive0_q <= drive0_d;
      drive1_q <= drive1_d;
      drive2_q <= drive2_d;
      prev_a_q <= i_pin[`GPPW_PORT_A];
      // Read edge stands for the instruction's second phase; no input latch
      rdata_q <= i_rd ? rdata_d : rdata_q;
      wake_q <= wake_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_pin_out = data_q;
  assign o_pin_oe = oe_q;
  assign o_pullup_en = pullup_en_q;
  assign o_pullup_strong = strength_q[`GPPW_BIT_STRENGTH];
  assign o_drive_sel0 = drive0_q;
  assign o_drive_sel1 = drive1_q;
  assign o_drive_sel2 = drive2_q;
  assign o_wake_req = wake_q;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence s_rd_port_a;
    i_rd && f_hit(i_addr, `GPPW_PORT_A, GPPW_KIND_DATA);
  endsequence

  chk_read_input_live: assert property (s_rd_port_a |=>
    ((o_rdata ^ $past(i_pin[0])) & $past(dir_q[0])) == 8'h00)
    else $error("input pin read does not match pin level");
  chk_read_output_latch: assert property (s_rd_port_a |=>
    ((o_rdata ^ $past(data_q[0])) & ~$past(dir_q[0])) == 8'h00)
    else $error("output pin read does not match latch");
  chk_latch_holds: assert property (
    !(i_wr && f_hit(i_addr, `GPPW_PORT_A, GPPW_KIND_DATA)) |=> $stable(o_pin_out[0]))
    else $error("output latch changed without a write");
  chk_dir_switch: assert property (
    (i_wr && f_hit(i_addr, `GPPW_PORT_A, GPPW_KIND_DIR)) |=> o_pin_oe[0] == ~$past(i_wdata))
    else $error("direction write did not switch pins");
  chk_oe_inverse_dir: assert property (o_pin_oe[1] == ~dir_q[1])
    else $error("output enable not inverse of direction");
  chk_pull_off_driven: assert property ((o_pullup_en[2] & o_pin_oe[2]) == 8'h00)
    else $error("pull-up on while pin driven");
  chk_pull_gated: assert property (
    ##1 ((o_pullup_en[0] & ~$past(i_func_logic_in[0] | i_func_nmos_out[0])) == 8'h00))
    else $error("pull-up on for a disallowed function");
  chk_strength_bit: assert property (
    (i_wr && i_addr == `GPPW_OFS_STRENGTH) |=> o_pullup_strong == $past(i_wdata[0]))
    else $error("pull-up strength not updated");
  chk_wake_edge: assert property (
    (i_power_down && |(prev_a_q & ~i_pin[0] & wake_en_q & i_porta_gpio)) |=> o_wake_req)
    else $error("enabled falling edge gave no wake request");
  chk_wake_mode: assert property (o_wake_req |-> $past(i_power_down))
    else $error("wake request outside power-down");
  chk_wake_once: assert property (o_wake_req ##1 $stable(i_pin[0]) |=> !o_wake_req)
    else $error("wake request repeated without new edge");
  chk_unimpl_zero: assert property (
    (o_pin_out[3][7:4] == 4'h0) && (dir_q[4][7:5] == 3'h0) && (drive1_q[7:6] == 2'h0))
    else $error("unimplemented bits not zero");

  // Two sampled steps: armed high, then low one edge later
  sequence s_a0_armed;
    i_power_down && wake_en_q[0] && i_porta_gpio[0] && i_pin[`GPPW_PORT_A][0];
  endsequence
  sequence s_a0_fallen;
    i_power_down && wake_en_q[0] && i_porta_gpio[0] && !i_pin[`GPPW_PORT_A][0];
  endsequence

  chk_data_write: assert property (
    (i_wr && f_hit(i_addr, `GPPW_PORT_A, GPPW_KIND_DATA))
    |=> o_pin_out[`GPPW_PORT_A] == $past(i_wdata))
    else $error("output latch did not take written data");
  chk_pull_follows: assert property (
    ##1 (o_pullup_en[1] ==
    (pull_q[1] & dir_q[1] & $past(i_func_logic_in[1] | i_func_nmos_out[1]))))
    else $error("pull-up does not follow its enable bit");
  chk_wake_en_write: assert property (
    wr_wake_hit
    |=> wake_en_q == $past(i_wdata))
    else $error("wake enable write not taken");
  chk_wake_disabled: assert property (
    (wake_en_q == `GPPW_RST_ZERO)
    |=> !o_wake_req)
    else $error("wake request with all enables off");
  chk_wake_gpio_only: assert property (
    ((wake_en_q & i_porta_gpio) == `GPPW_RST_ZERO)
    |=> !o_wake_req)
    else $error("wake request from a non-gpio pin");
  chk_wake_a0_steps: assert property (
    s_a0_armed ##1 s_a0_fallen
    |=> o_wake_req)
    else $error("falling edge on first pin gave no wake request");
  chk_drive0_write: assert property (
    wr_drive0_hit
    |=> o_drive_sel0 == $past(i_wdata))
    else $error("first drive register write not taken");
  chk_drive1_mask: assert property (
    wr_drive1_hit
    |=> o_drive_sel1 == ($past(i_wdata) & `GPPW_MASK_DRIVE1))
    else $error("second drive register write wrong");
  chk_drive2_write: assert property (
    wr_drive2_hit
    |=> o_drive_sel2 == $past(i_wdata))
    else $error("third drive register write not taken");
  chk_strength_upper: assert property (
    strength_q[7:1]
    == 7'h00)
    else $error("strength register upper bits set");
  chk_strength_read: assert property (
    (i_rd && i_addr == `GPPW_OFS_STRENGTH)
    |=> o_rdata == {7'h00, $past(o_pullup_strong)})
    else $error("strength read back wrong");
  chk_drive1_read: assert property (
    (i_rd && i_addr == `GPPW_OFS_DRIVE1)
    |=> o_rdata[7:6] == 2'b00)
    else $error("second drive register top bits read nonzero");
  chk_unmapped_read: assert property (
    (i_rd && !port_valid && !reg_hit)
    |=> o_rdata == `GPPW_RST_ZERO)
    else $error("unmapped address read nonzero");
  chk_read_holds: assert property (
    !i_rd
    |=> $stable(o_rdata))
    else $error("read data changed without a read");
  chk_port_d_unused: assert property (
    (o_pin_oe[3][7:4] == 4'h0) && (o_pullup_en[3][7:4] == 4'h0) &&
    (o_pin_out[4][7:5] == 3'h0))
    else $error("missing pins of short ports active");
  chk_dir_port_e: assert property (
    (i_wr && f_hit(i_addr, `GPPW_PORT_E, GPPW_KIND_DIR))
    |=> o_pin_oe[`GPPW_PORT_E] == (~$past(i_wdata) & `GPPW_MASK_PORT_E))
    else $error("short port direction write wrong");
  chk_data_port_d: assert property (
    (i_wr && f_hit(i_addr, `GPPW_PORT_D, GPPW_KIND_DATA))
    |=> o_pin_out[`GPPW_PORT_D] == ($past(i_wdata) & `GPPW_MASK_PORT_D))
    else $error("short port data write wrong");
  chk_pull_off_b: assert property (
    (o_pullup_en[1] & o_pin_oe[1])
    == 8'h00)
    else $error("pull-up on while pin driven");
  chk_oe_port_f: assert property (
    o_pin_oe[5]
    == ~dir_q[5])
    else $error("output enable not inverse of direction");
  chk_wake_en_read: assert property (
    (i_rd && f_hit(i_addr, `GPPW_PORT_A, GPPW_KIND_WAKE))
    |=> o_rdata == $past(wake_en_q))
    else $error("wake enable read back wrong");
endmodule

// ==== sim/gppw_board.sv ====
// Board model: external drivers and pull-ups on every pin
module gppw_board (
  // Pad side of the block
  input wire gppw_pkg::gppw_ports_t i_pin_out,
  input wire gppw_pkg::gppw_ports_t i_pin_oe,
  input wire gppw_pkg::gppw_ports_t i_pullup_en,
  // Board drive
  input wire gppw_pkg::gppw_ports_t i_ext,
  input wire gppw_pkg::gppw_ports_t i_ext_en,
  output gppw_pkg::gppw_ports_t o_level
);
  timeunit 1ns;
  timeprecision 1ns;
  import gppw_pkg::*;
  // Floating lines show the inverse of the latch, so a missing pull-up cannot pass
  // pull-up lifts released lines
  assign o_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_en & i_ext)
    | (~i_pin_oe & ~i_ext_en & (i_pullup_en | ~i_pin_out));
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench of the six-port GPIO block
`include "gppw_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import gppw_pkg::*;
  logic i_clock, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_power_down = 1'b0;
  logic o_pullup_strong, o_wake_req;
  gppw_byte_t i_addr = '0, i_wdata = '0, i_porta_gpio = 8'hff, o_rdata;
  gppw_byte_t o_drive_sel0, o_drive_sel1, o_drive_sel2, dat, dir, pul;
  gppw_ports_t i_func_logic_in = '0, i_func_nmos_out = '0, ext = '0, ext_en = '1;
  gppw_ports_t i_pin, o_pin_out, o_pin_oe, o_pullup_en;
  int fail_count = 0, num_checks = 0, cycles = 0, wakes, p;
  logic [31:0] seed = 32'h2f7c_5964;

  gppw_top DUT (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr),
    .i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(i_pin),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .i_func_logic_in(i_func_logic_in),
    .i_func_nmos_out(i_func_nmos_out), .i_porta_gpio(i_porta_gpio),
    .o_pullup_en(o_pullup_en), .o_pullup_strong(o_pullup_strong),
    .o_drive_sel0(o_drive_sel0), .o_drive_sel1(o_drive_sel1),
    .o_drive_sel2(o_drive_sel2), .i_power_down(i_power_down), .o_wake_req(o_wake_req));
  gppw_board board (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_pullup_en(o_pullup_en),
    .i_ext(ext), .i_ext_en(ext_en), .o_level(i_pin));

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  function automatic gppw_byte_t rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0] ^ seed[22:15];
  endfunction
  function automatic gppw_byte_t pmask(input int q);
    return q == 3 ? `GPPW_MASK_PORT_D : (q == 4 ? `GPPW_MASK_PORT_E : `GPPW_MASK_FULL);
  endfunction

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input gppw_byte_t a, input gppw_byte_t d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input gppw_byte_t a, input gppw_byte_t exp);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(48'(o_rdata), 48'(exp));
  endtask
  // Pin A0 falls and stays low; count the cycles the request is up
  task automatic wake(input gppw_byte_t en, input logic pd, input gppw_byte_t g, input int n);
    wr(8'h03, en);
    i_power_down <= pd;
    i_porta_gpio <= g;
    ext[0] <= 8'hff;
    repeat (2) @(posedge i_clock);
    ext[0] <= 8'hfe;
    wakes = 0;
    repeat (5) begin
      @(posedge i_clock);
      #1;
      wakes += int'(o_wake_req);
    end
    chk(48'(wakes), 48'(n));
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Far above the few hundred cycles the sequence needs
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    #1;
    chk(o_pin_out, 48'hff1f_0fff_ffff);
    chk(o_pin_oe | o_pullup_en, 48'h0);
    chk({o_drive_sel0, o_drive_sel1, o_drive_sel2, 23'h0, o_pullup_strong}, 48'h0);
    for (p = 0; p < 6; p++) begin
      rd(8'(p * 4 + 1), pmask(p));
      rd(8'(p * 4 + 2), 8'h00);
    end
    rd(8'h03, 8'h00);
    repeat (40) begin
      p = int'(rnd()) % 6;
      dat = rnd();
      dir = rnd();
      pul = rnd();
      ext[p] <= rnd();
      i_func_logic_in[p] <= rnd();
      i_func_nmos_out[p] <= rnd() & 8'h0f;
      wr(8'(p * 4), dat);
      wr(8'(p * 4 + 1), dir);
      wr(8'(p * 4 + 2), pul);
      chk(48'(o_pin_out[p]), 48'(dat & pmask(p)));
      chk(48'(o_pin_oe[p]), 48'(~dir & pmask(p)));
      chk(48'(o_pullup_en[p]),
        48'(pul & dir & pmask(p) & (i_func_logic_in[p] | i_func_nmos_out[p])));
      rd(8'(p * 4), ((dir & ext[p]) | (~dir & dat)) & pmask(p));
    end
    wr(8'h00, 8'hff);
    wr(8'h01, 8'hff);
    wr(8'h02, 8'hff);
    i_func_logic_in[0] <= 8'hff;
    i_func_nmos_out[0] <= 8'h00;
    ext_en[0] <= 8'h00;
    rd(8'h00, 8'hff);
    i_func_logic_in[0] <= 8'h0f;
    rd(8'h00, 8'h0f);
    wr(8'h02, 8'h00);
    rd(8'h00, 8'h00);
    ext_en[0] <= 8'hff;
    wr(`GPPW_OFS_STRENGTH, 8'hff);
    chk(48'(o_pullup_strong), 48'h1);
    rd(`GPPW_OFS_STRENGTH, 8'h01);
    for (p = 0; p < 3; p++) begin
      dat = p == 1 ? 8'hff : rnd();
      wr(8'(`GPPW_OFS_DRIVE0 + p), dat);
      chk(48'(p == 0 ? o_drive_sel0 : (p == 1 ? o_drive_sel1 : o_drive_sel2)),
        48'(p == 1 ? dat & `GPPW_MASK_DRIVE1 : dat));
      rd(8'(`GPPW_OFS_DRIVE0 + p), p == 1 ? dat & `GPPW_MASK_DRIVE1 : dat);
    end
    rd(8'h1c, 8'h00);
    rd(8'h07, 8'h00);
    wake(8'h01, 1'b1, 8'hff, 1);
    wake(8'h02, 1'b1, 8'hff, 0);
    wake(8'h01, 1'b0, 8'hff, 0);
    wake(8'h01, 1'b1, 8'hfe, 0);
    tally_and_finish();
  end
endmodule
